// ### design/sclv_device.sv
`timescale 1ns/10ps
// Behaviour
// - fixed type and revision identity bytes
// - firmware version major, minor, sub fields
// - saturation flag sticky, clear on read
// - ready interrupt pulls pin low when enabled
// - two-bit gain field drives sensor channels
// - ready flag sticky, pollable, clear on read
// - soft reset bit self-clears when done
// - integration time is value times 2.8ms
// - temperature byte read-only unsigned Celsius
// - auto learn when history bit zero
// - targets ignored while learning
// - history bit persistent, factory reset clears
// - host may request learn after history
// - learn guides host through string steps
// - factory reset erases, soft resets, self-clears
// - fresh learn after every factory reset
// - multi-byte big-endian, ascending access
// - write addresses carry bit 7 set
module sclv_device #(
  parameter logic [7:0] DEVICE_TYPE = 8'hA5, // Arbitrary value
  parameter logic [7:0] HW_REVISION = 8'h5A, // Arbitrary value
  parameter logic [7:0] FW_MAJOR = 8'h01,
  parameter logic [5:0] FW_MINOR = 6'h02,
  parameter logic [5:0] FW_SUB = 6'h03,
  parameter int INTEG_STEP = sclv_pkg::INTEG_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register link
  sclv_if.device bus,
  // Sensor side
  input wire logic saturated_i,
  input wire logic conv_done_i,
  input wire logic [7:0] temperature_i,
  output logic [1:0] gain_o,
  output logic [7:0] integration_time_o,
  output logic integ_tick_o,
  output logic soft_reset_o,
  // Persistent memory
  input wire logic history_stored_i,
  output logic history_write_o,
  output logic history_value_o,
  // Learn
  input wire logic learn_done_i,
  output logic learning_o,
  output logic [1:0] learn_step_o,
  output logic targets_enable_o
);
  typedef enum {SCLV_IDLE, SCLV_ERASE, SCLV_SRST} sclv_rst_state_e;
  sclv_rst_state_e rst_state_r;
  logic sat_r, rdy_r, rdy_ie_r, soft_r, factory_reset_request_r, learn_r, hist_r, hist_loaded_r, hist_wr_r;
  logic [1:0] gain_r, learn_step_r;
  logic [7:0] integ_r, rdata_r;
  logic [3:0] rst_cnt_r;
  logic [31:0] integ_cnt_r;
  logic ack_r, rd_cc_r;
  logic wr, rd;
  logic [6:0] idx;
  logic int_reset;
  assign idx = bus.addr[6:0];
  assign wr = bus.req && bus.addr[sclv_pkg::WRITE_FLAG_BIT];
  assign rd = bus.req && !bus.addr[sclv_pkg::WRITE_FLAG_BIT];
  assign int_reset = srst_i || (rst_state_r == SCLV_SRST);
  assign bus.ack = ack_r;
  assign bus.rdata = rdata_r;
  assign bus.int_n = !(rdy_ie_r && rdy_r);
  assign gain_o = gain_r;
  assign integration_time_o = integ_r;
  assign soft_reset_o = rst_state_r == SCLV_SRST;
  assign learning_o = learn_r;
  assign learn_step_o = learn_step_r;
  assign targets_enable_o = !learn_r;
  // Erase writes zero; a finished learn writes one
  assign history_value_o = hist_wr_r;
  assign history_write_o = (rst_state_r == SCLV_ERASE) || hist_wr_r;
  always_ff @(posedge clk_i) begin
    ack_r <= bus.req && !ack_r;
    rd_cc_r <= rd && !ack_r && idx == sclv_pkg::REG_CONVERSION_CONTROL;
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_r <= sclv_pkg::RESET_BYTE;
    end else if (rd && !ack_r) begin
      case (idx)
        sclv_pkg::REG_DEVICE_TYPE_ID: rdata_r <= DEVICE_TYPE;
        sclv_pkg::REG_HARDWARE_REVISION_ID: rdata_r <= HW_REVISION;
        sclv_pkg::REG_FIRMWARE_VERSION_HIGH: rdata_r <= {FW_MAJOR[3:0], FW_MINOR[5:2]};
        sclv_pkg::REG_FIRMWARE_VERSION_LOW: rdata_r <= {FW_MINOR[1:0], FW_SUB};
        sclv_pkg::REG_CONVERSION_CONTROL: rdata_r <= {sat_r, rdy_ie_r, gain_r, 2'h0, rdy_r, soft_r};
        sclv_pkg::REG_INTEGRATION_TIME: rdata_r <= integ_r;
        sclv_pkg::REG_DIE_TEMPERATURE: rdata_r <= temperature_i;
        sclv_pkg::REG_STRING_LEARN_INIT: rdata_r <= {5'h00, hist_r, learn_r, factory_reset_request_r};
        default: rdata_r <= sclv_pkg::RESET_BYTE;
      endcase
    end
  end
  // Flags: set wins over read clear; clear after the read completes
  always_ff @(posedge clk_i) begin
    if (int_reset) begin
      sat_r <= 1'b0;
      rdy_r <= 1'b0;
    end else begin
      sat_r <= saturated_i || (sat_r && !rd_cc_r);
      rdy_r <= conv_done_i || (rdy_r && !rd_cc_r);
    end
  end
  always_ff @(posedge clk_i) begin
    if (int_reset) begin
      rdy_ie_r <= 1'b0;
      gain_r <= sclv_pkg::SCLV_GAIN_1X;
      integ_r <= sclv_pkg::INTEG_DEFAULT;
    end else if (wr && !ack_r && idx == sclv_pkg::REG_CONVERSION_CONTROL) begin
      rdy_ie_r <= bus.wdata[sclv_pkg::CC_READY_INT_EN_BIT];
      gain_r <= bus.wdata[sclv_pkg::CC_GAIN_HI:sclv_pkg::CC_GAIN_LO];
    end else if (wr && !ack_r && idx == sclv_pkg::REG_INTEGRATION_TIME && bus.wdata != 8'h00) begin
      integ_r <= bus.wdata;
    end
  end
  // Integration tick every value times step
  always_ff @(posedge clk_i) begin
    if (int_reset) begin
      integ_cnt_r <= 32'h0;
      integ_tick_o <= 1'b0;
    end else if (integ_cnt_r + 32'h1 >= 32'(INTEG_STEP) * {24'h0, integ_r}) begin
      integ_cnt_r <= 32'h0;
      integ_tick_o <= 1'b1;
    end else begin
      integ_cnt_r <= integ_cnt_r + 32'h1;
      integ_tick_o <= 1'b0;
    end
  end
  // Soft and factory reset sequencing
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rst_state_r <= SCLV_IDLE;
      rst_cnt_r <= 4'h0;
      soft_r <= 1'b0;
      factory_reset_request_r <= 1'b0;
    end else begin
      case (rst_state_r)
        SCLV_IDLE: begin
          rst_cnt_r <= 4'h0;
          if (wr && !ack_r && idx == sclv_pkg::REG_STRING_LEARN_INIT
              && bus.wdata[sclv_pkg::SL_FACTORY_RESET_BIT]) begin
            factory_reset_request_r <= 1'b1;
            rst_state_r <= SCLV_ERASE;
          end else if (wr && !ack_r && idx == sclv_pkg::REG_CONVERSION_CONTROL
                       && bus.wdata[sclv_pkg::CC_SOFT_RESET_BIT]) begin
            soft_r <= 1'b1;
            rst_state_r <= SCLV_SRST;
          end
        end
        SCLV_ERASE: begin
          rst_cnt_r <= rst_cnt_r + 4'h1;
          if (rst_cnt_r == 4'(sclv_pkg::ERASE_CYCLES - 1)) begin
            rst_cnt_r <= 4'h0;
            soft_r <= 1'b1;
            rst_state_r <= SCLV_SRST;
          end
        end
        SCLV_SRST: begin
          rst_cnt_r <= rst_cnt_r + 4'h1;
          if (rst_cnt_r == 4'(sclv_pkg::SOFT_RESET_CYCLES - 1)) begin
            soft_r <= 1'b0;
            factory_reset_request_r <= 1'b0;
            rst_state_r <= SCLV_IDLE;
          end
        end
        default: rst_state_r <= SCLV_IDLE;
      endcase
    end
  end
  // Learn history and learn request
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hist_r <= 1'b0;
      hist_loaded_r <= 1'b0;
      learn_r <= 1'b0;
      learn_step_r <= 2'h0;
    end else if (!hist_loaded_r) begin
      hist_r <= history_stored_i;
      hist_loaded_r <= 1'b1;
    end else if (rst_state_r == SCLV_ERASE) begin
      hist_r <= 1'b0;
      learn_r <= 1'b0;
      learn_step_r <= 2'h0;
    end else if (learn_r) begin
      if (learn_done_i) begin
        learn_step_r <= learn_step_r + 2'h1;
        if (learn_step_r == 2'h2) begin
          learn_r <= 1'b0;
          learn_step_r <= 2'h0;
          hist_r <= 1'b1;
        end
      end
    end else if (!hist_r) begin
      learn_r <= 1'b1;
    end else if (wr && !ack_r && idx == sclv_pkg::REG_STRING_LEARN_INIT
                 && bus.wdata[sclv_pkg::SL_LEARN_BIT]) begin
      learn_r <= 1'b1;
    end
  end
  // Store the history bit in persistent memory once a learn completes
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hist_wr_r <= 1'b0;
    end else begin
      hist_wr_r <= hist_loaded_r && (rst_state_r != SCLV_ERASE) && learn_r && learn_done_i
                   && (learn_step_r == 2'h2);
    end
  end
endmodule : sclv_device

// ### design/sclv_pkg.sv
package sclv_pkg;
  // Virtual register indices
  localparam logic [6:0] REG_DEVICE_TYPE_ID = 7'h00;
  localparam logic [6:0] REG_HARDWARE_REVISION_ID = 7'h01;
  localparam logic [6:0] REG_FIRMWARE_VERSION_HIGH = 7'h02;
  localparam logic [6:0] REG_FIRMWARE_VERSION_LOW = 7'h03;
  localparam logic [6:0] REG_CONVERSION_CONTROL = 7'h04;
  localparam logic [6:0] REG_INTEGRATION_TIME = 7'h05;
  localparam logic [6:0] REG_DIE_TEMPERATURE = 7'h06;
  localparam logic [6:0] REG_STRING_LEARN_INIT = 7'h08;
  localparam int WRITE_FLAG_BIT = 7;
  // conversion_control fields
  localparam int CC_SATURATION_BIT = 7;
  localparam int CC_READY_INT_EN_BIT = 6;
  localparam int CC_GAIN_HI = 5;
  localparam int CC_GAIN_LO = 4;
  localparam int CC_READY_BIT = 1;
  localparam int CC_SOFT_RESET_BIT = 0;
  // string_learn_init fields
  localparam int SL_HISTORY_BIT = 2;
  localparam int SL_LEARN_BIT = 1;
  localparam int SL_FACTORY_RESET_BIT = 0;
  // Firmware version field positions
  localparam int FW_MINOR_HI_HI = 3;
  localparam int FW_MINOR_LO_HI = 7;
  localparam int FW_MINOR_LO_LO = 6;
  localparam int FW_SUB_HI = 5;
  // Gain encodings
  typedef enum logic [1:0] {
    SCLV_GAIN_1X = 2'h0,
    SCLV_GAIN_3P7X = 2'h1,
    SCLV_GAIN_16X = 2'h2,
    SCLV_GAIN_64X = 2'h3
  } sclv_gain_e;
  // Integration step
  localparam int INTEG_STEP_US = 2800;
  localparam int CLK_MHZ = 200;
  localparam int INTEG_STEP_CYCLES = INTEG_STEP_US * CLK_MHZ;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] INTEG_DEFAULT = 8'h01;
  localparam int SOFT_RESET_CYCLES = 4;
  localparam int ERASE_CYCLES = 8;
endpackage : sclv_pkg

// ### design/sclv_if.sv
`timescale 1ns/10ps
// Virtual register port between host end and device end
interface sclv_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic int_n;
  modport device (input req, input we, input addr, input wdata, output ack, output rdata, output int_n);
  modport host (output req, output we, output addr, output wdata, input ack, input rdata, input int_n);
endinterface : sclv_if

// ### design/sclv_host.sv
`timescale 1ns/10ps
module sclv_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // User command
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [6:0] cmd_index_i,
  input wire logic [7:0] cmd_wdata_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic irq_o,
  // Register link
  sclv_if.host bus
);
  logic busy_r, req_r, we_r, done_r;
  logic [7:0] addr_r, wdata_r, rdata_r;
  logic int_s1_r, int_s2_r;
  assign cmd_ready_o = !busy_r;
  assign done_o = done_r;
  assign rdata_o = rdata_r;
  assign irq_o = !int_s2_r;
  assign bus.req = req_r;
  assign bus.we = we_r;
  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  always_ff @(posedge clk_i) begin
    int_s1_r <= bus.int_n;
    int_s2_r <= int_s1_r;
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy_r <= 1'b0;
      req_r <= 1'b0;
      we_r <= 1'b0;
      done_r <= 1'b0;
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      rdata_r <= 8'h00;
    end else begin
      done_r <= 1'b0;
      if (!busy_r && cmd_valid_i) begin
        busy_r <= 1'b1;
        req_r <= 1'b1;
        we_r <= cmd_write_i;
        // Write address carries the flag bit
        addr_r <= {cmd_write_i, cmd_index_i};
        wdata_r <= cmd_wdata_i;
      end else if (busy_r && bus.ack) begin
        busy_r <= 1'b0;
        req_r <= 1'b0;
        done_r <= 1'b1;
        if (!we_r) begin
          rdata_r <= bus.rdata;
        end
      end
    end
  end
endmodule : sclv_host

// ### bench/sclv_checker_sva.sv
`timescale 1ns/10ps
module sclv_checker_sva #(
  parameter logic [7:0] DEVICE_TYPE = 8'hA5,
  parameter logic [7:0] HW_REVISION = 8'h5A,
  parameter logic [5:0] FW_MINOR = 6'h02,
  parameter logic [5:0] FW_SUB = 6'h03
) (
  // Interface signals
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic int_n
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic tk;
  logic rd;
  logic [7:0] integ_r;
  logic [2:0] ctl_r;
  logic k_r;
  assign tk = req && !ack;
  assign rd = tk && !we;
  // Shadow of the writable fields, valid until a soft or factory reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      integ_r <= 8'h01;
      ctl_r <= 3'h0;
      k_r <= 1'b1;
    end else if (tk && we) begin
      if (addr == 8'h85 && wdata != 8'h00) integ_r <= wdata;
      if (addr == 8'h84) ctl_r <= wdata[6:4];
      if ((addr == 8'h84 || addr == 8'h88) && wdata[0]) k_r <= 1'b0;
    end
  end
  property p_type; rd && addr == 8'h00 |=> ack && rdata == DEVICE_TYPE; endproperty
  a_type: assert property (p_type) else $error("type byte wrong");
  property p_rev; rd && addr == 8'h01 |=> ack && rdata == HW_REVISION; endproperty
  a_rev: assert property (p_rev) else $error("revision byte wrong");
  property p_fw_lo; rd && addr == 8'h03 |=> rdata == {FW_MINOR[1:0], FW_SUB}; endproperty
  a_fw_lo: assert property (p_fw_lo) else $error("firmware low byte wrong");
  property p_gain; rd && addr == 8'h04 && k_r |=> rdata[6:4] == ctl_r && rdata[3:2] == 2'h0; endproperty
  a_gain: assert property (p_gain) else $error("control fields wrong");
  property p_integ; rd && addr == 8'h05 && k_r |=> rdata == integ_r; endproperty
  a_integ: assert property (p_integ) else $error("integration time wrong");
  property p_int_off; k_r && !ctl_r[2] && !req |-> int_n; endproperty
  a_int_off: assert property (p_int_off) else $error("interrupt while disabled");
  property p_int_on; ack && !we && addr == 8'h04 && rdata[6] && rdata[1] |-> !int_n; endproperty
  a_int_on: assert property (p_int_on) else $error("interrupt missing");
  property p_lrn; rd && addr == 8'h08 |=> ack ##1 !ack && $stable(rdata) && rdata[7:3] == 5'h00; endproperty
  a_lrn: assert property (p_lrn) else $error("learn byte wrong");
endmodule : sclv_checker_sva

// ### bench/sensor_control_version_learn_regs_bench.sv
`timescale 1ns/10ps
module sensor_control_version_learn_regs_bench;
  localparam logic [7:0] DT = 8'h3C; // Arbitrary value
  localparam logic [7:0] HR = 8'hC3; // Arbitrary value
  localparam logic [5:0] FM = 6'h2D;
  localparam logic [5:0] FS = 6'h15;
  localparam logic [7:0] FJ = 8'h07;
  logic clk_i = 1'b0, srst_i = 1'b1, cv = 1'b0, cw = 1'b0, crdy, done, irq, sat = 1'b0, conv = 1'b0;
  logic [6:0] ci = 7'h00;
  logic [7:0] cd = 8'h00, rdata, temp = 8'h00, integ, d;
  logic [1:0] gain, step;
  logic tick, srs, hist = 1'b0, hwr, hval, ld = 1'b0, lrn, tgt, saw_sr = 1'b0, saw_hw = 1'b0;
  logic [15:0] notes[$];
  logic [15:0] nt;
  logic [31:0] rnd = 32'hDB4E;
  int fails = 0, compares = 0, cyc = 0, n;
  always #2.5 clk_i = ~clk_i;
  sclv_if link();
  sclv_host sclv_host_i (.clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cv), .cmd_write_i(cw), .cmd_index_i(ci),
    .cmd_wdata_i(cd), .cmd_ready_o(crdy), .done_o(done), .rdata_o(rdata), .irq_o(irq), .bus(link.host));
  sclv_device #(.DEVICE_TYPE(DT), .HW_REVISION(HR), .FW_MAJOR(FJ), .FW_MINOR(FM), .FW_SUB(FS),
    .INTEG_STEP(4)) sclv_device_i (
    .clk_i(clk_i), .srst_i(srst_i), .bus(link.device), .saturated_i(sat), .conv_done_i(conv), .temperature_i(temp),
    .gain_o(gain), .integration_time_o(integ), .integ_tick_o(tick), .soft_reset_o(srs), .history_stored_i(hist),
    .history_write_o(hwr), .history_value_o(hval), .learn_done_i(ld), .learning_o(lrn), .learn_step_o(step),
    .targets_enable_o(tgt));
  sclv_checker_sva #(.DEVICE_TYPE(DT), .HW_REVISION(HR), .FW_MINOR(FM), .FW_SUB(FS)) sclv_checker_sva_i (
    .clk_i(clk_i), .srst_i(srst_i), .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata),
    .ack(link.ack), .rdata(link.rdata), .int_n(link.int_n));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic ck(input string nm, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : ck
  // One register access; mask zero means nothing to compare
  task automatic rw(input logic w, input logic [6:0] i, input logic [7:0] wd, input logic [7:0] m, input logic [7:0] e);
    notes.push_back({m, e});
    @(negedge clk_i);
    cv = 1'b1;
    cw = w;
    ci = i;
    cd = wd;
    do @(posedge clk_i); while (crdy !== 1'b1);
    @(negedge clk_i) cv = 1'b0;
    do @(negedge clk_i); while (done !== 1'b1);
    @(negedge clk_i);
  endtask : rw
  task automatic lp(input int k);
    repeat (k) begin
      @(negedge clk_i) ld = 1'b1;
      @(negedge clk_i) ld = 1'b0;
    end
    repeat (2) @(negedge clk_i);
  endtask : lp
  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  always @(negedge clk_i) begin
    if (done === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      ck("rdata", nt[7:0] & nt[15:8], rdata & nt[15:8]);
    end
    if (hwr === 1'b1) hist <= hval;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (srs === 1'b1) saw_sr <= 1'b1;
    if (hwr === 1'b1 && hval === 1'b0) saw_hw <= 1'b1;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i) srst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    rw(0, 7'h08, 0, 8'h07, 8'h02);
    for (int s = 0; s < 3; s++) begin
      ck("step", s[7:0], {6'h00, step});
      ck("tgt", 8'h00, {7'h00, tgt});
      lp(1);
    end
    ck("tgt", 8'h01, {7'h00, tgt});
    rw(0, 7'h08, 0, 8'h07, 8'h04);
    // Power cycle: the stored history must survive and suppress a new learn
    @(negedge clk_i) srst_i = 1'b1;
    repeat (6) @(negedge clk_i);
    srst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    rw(0, 7'h08, 0, 8'h07, 8'h04);
    ck("persist", 8'h00, {7'h00, lrn});
    $display("test learn done");
    rw(1, 7'h00, 8'h00, 0, 0);
    rw(0, 7'h00, 0, 8'hFF, DT);
    rw(0, 7'h01, 0, 8'hFF, HR);
    rw(0, 7'h02, 0, 8'hFF, {FJ[3:0], FM[5:2]});
    rw(0, 7'h03, 0, 8'hFF, {FM[1:0], FS});
    rw(0, 7'h07, 0, 8'hFF, 8'h00);
    rnd = lfsr(rnd);
    temp = rnd[15:8];
    rw(0, 7'h06, 0, 8'hFF, temp);
    d = {4'h0, rnd[3:0]} | 8'h01;
    rw(1, 7'h05, d, 0, 0);
    rw(1, 7'h05, 8'h00, 0, 0);
    rw(0, 7'h05, 0, 8'hFF, d);
    ck("integ", d, integ);
    do @(posedge clk_i); while (tick !== 1'b1);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tick !== 1'b1 && n < 300);
    ck("period", d * 4, n[7:0]);
    $display("test identity and timing done");
    for (int g = 0; g < 4; g++) begin
      rw(1, 7'h04, {2'h0, g[1:0], 4'h0}, 0, 0);
      ck("gain", {6'h00, g[1:0]}, {6'h00, gain});
      rw(0, 7'h04, 0, 8'h30, {2'h0, g[1:0], 4'h0});
    end
    for (int e = 0; e < 2; e++) begin
      rw(1, 7'h04, {1'b0, e[0], 6'h00}, 0, 0);
      @(negedge clk_i) {sat, conv} = 2'h3;
      @(negedge clk_i) {sat, conv} = 2'h0;
      repeat (4) @(negedge clk_i);
      ck("irq", {7'h00, e[0]}, {7'h00, irq});
      rw(0, 7'h04, 0, 8'hC2, {1'b1, e[0], 6'h02});
      rw(0, 7'h04, 0, 8'h82, 8'h00);
      repeat (4) @(negedge clk_i);
      ck("irq", 8'h00, {7'h00, irq});
    end
    $display("test flags done");
    rw(1, 7'h04, 8'h01, 0, 0);
    repeat (8) @(negedge clk_i);
    ck("soft", 8'h01, {7'h00, saw_sr});
    rw(0, 7'h04, 0, 8'h01, 8'h00);
    rw(1, 7'h08, 8'h02, 0, 0);
    ck("relearn", 8'h01, {7'h00, lrn});
    lp(3);
    ck("relearn", 8'h00, {7'h00, lrn});
    rw(1, 7'h08, 8'h01, 0, 0);
    repeat (20) @(negedge clk_i);
    ck("erase", 8'h01, {7'h00, saw_hw});
    rw(0, 7'h08, 0, 8'h07, 8'h02);
    ck("fresh", 8'h01, {7'h00, lrn});
    $display("test resets done");
    end_sim();
  end
endmodule : sensor_control_version_learn_regs_bench
